// >>> inc/scs_pkg.sv
package scs_pkg;

    // ----------------------------------------
    // Register port and tick counter widths
    // ----------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int TICK_W = 16;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [15:0] ADDR_STATUS = 16'h2000;
    localparam logic [15:0] ADDR_SOFT_RESET = 16'h2004;
    localparam logic [15:0] ADDR_IRQ_CLOCK = 16'h2005;
    localparam logic [15:0] ADDR_TICK_HI = 16'h2016;
    localparam logic [15:0] ADDR_TICK_LO = 16'h2017;
    localparam logic [15:0] ADDR_TICK_CLEAR = 16'h2020;

    // Windows of the configuration registers kept outside this block
    localparam logic [15:0] ADDR_NET_FIRST = 16'h4120;
    localparam logic [15:0] ADDR_NET_LAST = 16'h416F;
    localparam logic [15:0] ADDR_GW6_FIRST = 16'h4170;
    localparam logic [15:0] ADDR_GW6_LAST = 16'h417F;
    localparam logic [15:0] ADDR_PHY_CTRL0 = 16'h3000;
    localparam logic [15:0] ADDR_PHY_CTRL1 = 16'h3001;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BIT_CHIP_LOCK = 7;
    localparam int BIT_NET_LOCK = 6;
    localparam int BIT_PHY_LOCK = 5;
    localparam int BIT_PAR_MODE = 1;
    localparam int BIT_SPI_MODE = 0;
    localparam int BIT_SRST = 7;
    localparam int BIT_IEN = 7;
    localparam int BIT_SYS_CLOCK_SELECT = 0;

    // ----------------------------------------
    // Reset values and mode pin patterns
    // ----------------------------------------
    localparam logic [7:0] SOFT_RESET_RST = 8'h80;
    localparam logic [7:0] IRQ_CLOCK_RST = 8'h80;
    localparam logic [15:0] TICK_RST = 16'h0000;
    localparam logic [7:0] DATA_ZERO = 8'h00;
    localparam logic [2:0] MODE_PAR_PAT = 3'h2;
    localparam logic [2:0] MODE_SPI_PAT = 3'h0;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_PERIOD_US = 100;
    localparam int TICK_CYCLES = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam int SRST_HOLD_CYCLES = 4;

    // ----------------------------------------
    // Soft reset sequencer states
    // ----------------------------------------
    typedef enum logic [2:0] {
        SCS_RUN = 3'b001,
        SCS_HOLD = 3'b010,
        SCS_DONE = 3'b100
    } scs_state_type;

endpackage : scs_pkg

// >>> rtl/scs_tick_gen.sv
`timescale 1ns/10ps
module scs_tick_gen
    import scs_pkg::*;
#(
    parameter int CYCLES = TICK_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control
    input wire logic restart,
    // Tick
    output logic tick
);

    localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count_ff;
    logic tick_ff;

    // ----------------------------------------
    // Prescaler
    // ----------------------------------------
    // Restart realigns the period so the first tick comes a full period
    // after a clear.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_ff <= '0;
        end
        else if (restart || count_ff == LAST)
        begin
            count_ff <= '0;
        end
        else
        begin
            count_ff <= count_ff + CW'(1);
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tick_ff <= 1'b0;
        end
        else
        begin
            tick_ff <= !restart && count_ff == LAST;
        end
    end

    assign tick = tick_ff;

endmodule : scs_tick_gen

// >>> rtl/scs_regs.sv
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
// Operation
// - Status register shows chip, network, PHY lock in bits 7,6,5; 4..2 zero.
// - Network lock set blocks writes to network configuration registers.
// - IPv6 gateway register writes always pass, whatever the network lock.
// - PHY lock set blocks writes to both PHY control registers.
// - Status bit 1 reads 1 when mode pins match 010X.
// - Status bit 0 reads 1 when mode pins match 000X.
// - Writing 0 to soft reset bit 7 reinitialises all registers; reads 0x80.
// - Soft reset write only accepted while chip lock is 0.
// - Interrupt enable 0 holds the active-low interrupt output high.
// - Interrupt enable 1 drives interrupt output low on an enabled event.
// - Bit 0 selects 100MHz or 25MHz clock; changeable only when unlocked.
// - 16-bit tick counter from zero, increments every 100us, at 0x2016.
// - Any write to the tick clear register zeroes the tick counter.
module scs_regs
    import scs_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES,
    parameter int SRST_HOLD_P = SRST_HOLD_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // Lock states from the lock control registers
    input wire logic chip_lock_flag,
    input wire logic network_lock_flag,
    input wire logic phy_lock_flag,
    // Host mode strap pins
    input wire logic [3:0] mode_pins,
    // Interrupt
    input wire logic irq_event_pending,
    output logic interrupt_out_n,
    // Clock select and soft reset
    output logic sys_clock_select,
    output logic soft_reset_out,
    // Gated writes to configuration registers kept elsewhere
    output logic net_cfg_wr,
    output logic ipv6_gw_wr,
    output logic phy_ctrl_wr
);

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic in_range(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] lo,
        input logic [ADDR_W-1:0] hi
    );
        in_range = a >= lo && a <= hi;
    endfunction : in_range

    function automatic logic is_reg(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] target
    );
        is_reg = a == target;
    endfunction : is_reg

    localparam logic [2:0] HOLD_LAST = 3'(SRST_HOLD_P - 1);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [3:0] mode_meta_ff;
    logic [3:0] mode_sync_ff;
    logic [7:0] irq_clock_ff;
    logic [TICK_W-1:0] tick_count_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic irq_n_ff;
    scs_state_type state_ff;
    scs_state_type nxt_state;
    logic [2:0] hold_cnt_ff;
    logic wr_soft_reset;
    logic wr_irq_clock;
    logic wr_tick_clear;
    logic soft_reset_req;
    logic tick;
    logic tick_restart;
    logic par_mode;
    logic spi_mode;
    logic [7:0] status_value;
    logic [DATA_W-1:0] nxt_rdata;

    // ----------------------------------------
    // Mode pin synchroniser
    // ----------------------------------------
    // Straps are pins, so they cross two flops before any decode.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode_meta_ff <= '0;
            mode_sync_ff <= '0;
        end
        else
        begin
            mode_meta_ff <= mode_pins;
            mode_sync_ff <= mode_meta_ff;
        end
    end

    // Lowest pin is a don't-care in both patterns
    assign par_mode = mode_sync_ff[3:1] == MODE_PAR_PAT;
    assign spi_mode = mode_sync_ff[3:1] == MODE_SPI_PAT;

    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    // Status and tick counter have no write decode at all.
    assign wr_soft_reset = reg_wr && is_reg(reg_addr, ADDR_SOFT_RESET);
    assign wr_irq_clock = reg_wr && is_reg(reg_addr, ADDR_IRQ_CLOCK);
    assign wr_tick_clear = reg_wr && is_reg(reg_addr, ADDR_TICK_CLEAR);

    // Reset is taken only when unlocked and bit 7 is written low
    assign soft_reset_req = wr_soft_reset && !chip_lock_flag
        && !reg_wdata[BIT_SRST];

    // ----------------------------------------
    // Gated configuration writes
    // ----------------------------------------
    // The gateway window is tested on its own so the lock never reaches it.
    assign net_cfg_wr = reg_wr && !network_lock_flag
        && in_range(reg_addr, ADDR_NET_FIRST, ADDR_NET_LAST);
    assign ipv6_gw_wr = reg_wr
        && in_range(reg_addr, ADDR_GW6_FIRST, ADDR_GW6_LAST);
    assign phy_ctrl_wr = reg_wr && !phy_lock_flag
        && (is_reg(reg_addr, ADDR_PHY_CTRL0)
        || is_reg(reg_addr, ADDR_PHY_CTRL1));

    // ----------------------------------------
    // Soft reset sequencer
    // ----------------------------------------
    // Local registers clear at once; the rest of the chip sees a level
    // held for a few cycles so slow logic catches it.
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            SCS_RUN:
            begin
                if (soft_reset_req)
                begin
                    nxt_state = SCS_HOLD;
                end
            end
            SCS_HOLD:
            begin
                if (hold_cnt_ff == HOLD_LAST)
                begin
                    nxt_state = SCS_DONE;
                end
            end
            SCS_DONE:
            begin
                nxt_state = SCS_RUN;
                // A request landing here would otherwise lose its pulse
                if (soft_reset_req)
                begin
                    nxt_state = SCS_HOLD;
                end
            end
            default:
            begin
                nxt_state = SCS_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_ff <= SCS_RUN;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hold_cnt_ff <= '0;
        end
        else if (state_ff == SCS_HOLD)
        begin
            hold_cnt_ff <= hold_cnt_ff + 3'h1;
        end
        else
        begin
            hold_cnt_ff <= '0;
        end
    end

    assign soft_reset_out = state_ff == SCS_HOLD;

    // ----------------------------------------
    // Interrupt enable and clock select
    // ----------------------------------------
    // Whole register is frozen by the chip lock; only bits 7 and 0 exist.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_clock_ff <= IRQ_CLOCK_RST;
        end
        else if (soft_reset_req)
        begin
            irq_clock_ff <= IRQ_CLOCK_RST;
        end
        else if (wr_irq_clock && !chip_lock_flag)
        begin
            irq_clock_ff[BIT_IEN] <= reg_wdata[BIT_IEN];
            irq_clock_ff[BIT_SYS_CLOCK_SELECT] <= reg_wdata[BIT_SYS_CLOCK_SELECT];
        end
    end

    assign sys_clock_select = irq_clock_ff[BIT_SYS_CLOCK_SELECT];

    // ----------------------------------------
    // Interrupt output
    // ----------------------------------------
    // Registered so the pin never glitches while enable and events settle.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_n_ff <= 1'b1;
        end
        else if (!irq_clock_ff[BIT_IEN])
        begin
            irq_n_ff <= 1'b1;
        end
        else
        begin
            irq_n_ff <= !irq_event_pending;
        end
    end

    assign interrupt_out_n = irq_n_ff;

    // ----------------------------------------
    // Tick counter
    // ----------------------------------------
    assign tick_restart = wr_tick_clear || soft_reset_req;

    scs_tick_gen #(
        .CYCLES(TICK_CYCLES_P)
    ) u_tick_gen (
        .clk(clk),
        .reset_n(reset_n),
        .restart(tick_restart),
        .tick(tick)
    );

    // Clear beats a tick landing in the same cycle; it is an initialise.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tick_count_ff <= TICK_RST;
        end
        else if (tick_restart)
        begin
            tick_count_ff <= TICK_RST;
        end
        else if (tick)
        begin
            tick_count_ff <= tick_count_ff + 16'h0001;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always_comb
    begin
        status_value = DATA_ZERO;
        status_value[BIT_CHIP_LOCK] = chip_lock_flag;
        status_value[BIT_NET_LOCK] = network_lock_flag;
        status_value[BIT_PHY_LOCK] = phy_lock_flag;
        status_value[BIT_PAR_MODE] = par_mode;
        status_value[BIT_SPI_MODE] = spi_mode;
    end

    // Counter halves are read separately, so a carry between the two
    // reads can tear the value; software should read twice if it cares.
    always_comb
    begin
        nxt_rdata = DATA_ZERO;
        if (reg_rd)
        begin
            unique case (1'b1)
                is_reg(reg_addr, ADDR_STATUS):
                begin
                    nxt_rdata = status_value;
                end
                is_reg(reg_addr, ADDR_SOFT_RESET):
                begin
                    nxt_rdata = SOFT_RESET_RST;
                end
                is_reg(reg_addr, ADDR_IRQ_CLOCK):
                begin
                    nxt_rdata = irq_clock_ff;
                end
                is_reg(reg_addr, ADDR_TICK_HI):
                begin
                    nxt_rdata = tick_count_ff[15:8];
                end
                is_reg(reg_addr, ADDR_TICK_LO):
                begin
                    nxt_rdata = tick_count_ff[7:0];
                end
                default:
                begin
                    nxt_rdata = DATA_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rdata_ff <= DATA_ZERO;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

endmodule : scs_regs

// >>> testbench/scs_regs_properties.sv
`timescale 1ns/10ps
module scs_regs_properties
    import scs_pkg::*;
#(
    parameter int TICK_CYCLES_P = 10,
    parameter int SRST_HOLD_P = 4
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    // Locks, pins and interrupt
    input wire logic chip_lock_flag,
    input wire logic network_lock_flag,
    input wire logic phy_lock_flag,
    input wire logic [3:0] mode_pins,
    input wire logic irq_event_pending,
    input wire logic interrupt_out_n,
    // Control outputs
    input wire logic sys_clock_select,
    input wire logic soft_reset_out,
    input wire logic net_cfg_wr,
    input wire logic ipv6_gw_wr,
    input wire logic phy_ctrl_wr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // ----------------------------------------
    // Shadow of the interrupt and clock register
    // ----------------------------------------
    logic ien_ff;
    logic sys_clock_select_ff;
    logic srst_wr;
    logic cfg_wr;
    assign srst_wr = reg_wr && reg_addr == ADDR_SOFT_RESET
        && !reg_wdata[BIT_SRST] && !chip_lock_flag;
    assign cfg_wr = reg_wr && reg_addr == ADDR_IRQ_CLOCK && !chip_lock_flag;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ien_ff <= 1'h1;
            sys_clock_select_ff <= 1'h0;
        end
        else if (srst_wr)
        begin
            ien_ff <= 1'h1;
            sys_clock_select_ff <= 1'h0;
        end
        else if (cfg_wr)
        begin
            ien_ff <= reg_wdata[BIT_IEN];
            sys_clock_select_ff <= reg_wdata[BIT_SYS_CLOCK_SELECT];
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    sequence s_srst_write;
        srst_wr && !soft_reset_out;
    endsequence
    // Synchroniser needs the pins steady before a read can trust them
    sequence s_pins_settled;
        $past(reset_n, 3) ##0 $stable(mode_pins) [*3];
    endsequence
    sequence s_status_read;
        reg_rd && reg_addr == ADDR_STATUS;
    endsequence

    chk_net_wr_gate: assert property (
        net_cfg_wr == (reg_wr && !network_lock_flag
            && reg_addr >= ADDR_NET_FIRST && reg_addr <= ADDR_NET_LAST))
        else $error("network write strobe wrong");
    chk_gw6_wr_open: assert property (
        ipv6_gw_wr == (reg_wr
            && reg_addr >= ADDR_GW6_FIRST && reg_addr <= ADDR_GW6_LAST))
        else $error("gateway write strobe wrong");
    chk_phy_wr_gate: assert property (
        phy_ctrl_wr == (reg_wr && !phy_lock_flag && (reg_addr ==
            ADDR_PHY_CTRL0 || reg_addr == ADDR_PHY_CTRL1)))
        else $error("phy write strobe wrong");
    chk_lock_status: assert property (
        s_status_read |=> reg_rdata[7:2] == {$past(chip_lock_flag),
            $past(network_lock_flag), $past(phy_lock_flag), 3'h0})
        else $error("lock status bits wrong");
    chk_par_mode: assert property (
        s_pins_settled ##0 s_status_read |=> reg_rdata[BIT_PAR_MODE]
            == ($past(mode_pins[3:1]) == MODE_PAR_PAT))
        else $error("parallel mode bit wrong");
    chk_spi_mode: assert property (
        s_pins_settled ##0 s_status_read |=> reg_rdata[BIT_SPI_MODE]
            == ($past(mode_pins[3:1]) == MODE_SPI_PAT))
        else $error("serial mode bit wrong");
    chk_irq_output: assert property (
        $past(reset_n) |->
            interrupt_out_n == !$past(ien_ff && irq_event_pending))
        else $error("interrupt output wrong");
    chk_clock_select: assert property (
        sys_clock_select == sys_clock_select_ff)
        else $error("clock select wrong");
    chk_srst_pulse: assert property (
        s_srst_write |=> $rose(soft_reset_out)
            ##SRST_HOLD_P $fell(soft_reset_out))
        else $error("soft reset pulse wrong");
    chk_srst_locked: assert property (
        reg_wr && reg_addr == ADDR_SOFT_RESET && chip_lock_flag
            && !soft_reset_out |=> !soft_reset_out)
        else $error("locked soft reset acted");
    chk_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == DATA_ZERO)
        else $error("read data outside its cycle");
    chk_tick_clear: assert property (
        reg_wr && reg_addr == ADDR_TICK_CLEAR ##[1:2]
            reg_rd && reg_addr == ADDR_TICK_LO |=> reg_rdata == DATA_ZERO)
        else $error("tick clear failed");
endmodule : scs_regs_properties

bind scs_regs scs_regs_properties #(
    .TICK_CYCLES_P(TICK_CYCLES_P),
    .SRST_HOLD_P(SRST_HOLD_P)
) chk_u (.*);

// >>> testbench/scs_regs_tb.sv
`timescale 1ns/10ps
module scs_regs_tb;
    import scs_pkg::*;
    // Short prescaler keeps the tick test to a few dozen cycles
    localparam int TCY = 10;
    localparam int SRST_H = 4;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [DATA_W-1:0] reg_rdata;
    logic chip_lock_flag = 1'h0;
    logic network_lock_flag = 1'h0;
    logic phy_lock_flag = 1'h0;
    logic [3:0] mode_pins = 4'h0;
    logic irq_event_pending = 1'h0;
    logic interrupt_out_n;
    logic sys_clock_select;
    logic soft_reset_out;
    logic net_cfg_wr;
    logic ipv6_gw_wr;
    logic phy_ctrl_wr;
    logic [2:0] strobes;
    int n_fail = 0;
    int total_checks = 0;

    scs_regs #(
        .TICK_CYCLES_P(TCY),
        .SRST_HOLD_P(SRST_H)
    ) dut_u (.*);

    always #2.5 clk = ~clk;

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        #1;
        strobes = {net_cfg_wr, ipv6_gw_wr, phy_ctrl_wr};
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask : wr

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1;
        check(reg_rdata, exp);
    endtask : rd_chk

    task automatic do_reset;
        @(posedge clk);
        reset_n <= 1'h0;
        repeat (10) @(posedge clk);
        reset_n <= 1'h1;
    endtask : do_reset

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        #1;
        check(interrupt_out_n, 1'h1);
        check(sys_clock_select, 1'h0);
        rd_chk(ADDR_IRQ_CLOCK, IRQ_CLOCK_RST);
        rd_chk(ADDR_TICK_HI, 8'h00);
        rd_chk(16'h2001, DATA_ZERO);
        $display("reset test done");
    endtask : t_reset

    task automatic t_status;
        for (int i = 0; i < 16; i++)
        begin
            @(posedge clk);
            {chip_lock_flag, network_lock_flag, phy_lock_flag} <= i[2:0];
            mode_pins <= i[3:0];
            repeat (3) @(posedge clk);
            rd_chk(ADDR_STATUS, {i[2:0], 3'h0, i[3:1] == MODE_PAR_PAT,
                i[3:1] == MODE_SPI_PAT});
        end
        wr(ADDR_STATUS, 8'h00);
        rd_chk(ADDR_STATUS, 8'hE0);
        @(posedge clk);
        {chip_lock_flag, network_lock_flag, phy_lock_flag} <= 3'h0;
        $display("status test done");
    endtask : t_status

    task automatic t_gates;
        logic [15:0] a [7] = '{ADDR_NET_FIRST, ADDR_NET_LAST, ADDR_GW6_FIRST,
            ADDR_GW6_LAST, ADDR_PHY_CTRL0, ADDR_PHY_CTRL1, 16'h411F};
        for (int l = 0; l < 2; l++)
            for (int k = 0; k < 7; k++)
            begin
                @(posedge clk);
                network_lock_flag <= l[0];
                phy_lock_flag <= l[0];
                wr(a[k], 8'h5A);
                check(strobes[2], k < 2 && l == 0);
                check(strobes[1], k inside {2, 3});
                check(strobes[0], k inside {4, 5} && l == 0);
            end
        $display("gate test done");
    endtask : t_gates

    task automatic t_irq_clk;
        wr(ADDR_IRQ_CLOCK, 8'h01);
        rd_chk(ADDR_IRQ_CLOCK, 8'h01);
        check(sys_clock_select, 1'h1);
        @(posedge clk);
        irq_event_pending <= 1'h1;
        repeat (3) @(posedge clk);
        #1;
        check(interrupt_out_n, 1'h1);
        wr(ADDR_IRQ_CLOCK, 8'h80);
        repeat (2) @(posedge clk);
        #1;
        check(interrupt_out_n, 1'h0);
        check(sys_clock_select, 1'h0);
        @(posedge clk);
        irq_event_pending <= 1'h0;
        chip_lock_flag <= 1'h1;
        repeat (2) @(posedge clk);
        #1;
        check(interrupt_out_n, 1'h1);
        wr(ADDR_IRQ_CLOCK, 8'h01);
        rd_chk(ADDR_IRQ_CLOCK, 8'h80);
        @(posedge clk);
        chip_lock_flag <= 1'h0;
        $display("interrupt clock test done");
    endtask : t_irq_clk

    task automatic t_tick;
        wr(ADDR_TICK_CLEAR, 8'h00);
        rd_chk(ADDR_TICK_LO, 8'h00);
        wr(ADDR_TICK_HI, 8'hAA);
        wr(ADDR_TICK_LO, 8'h55);
        rd_chk(ADDR_TICK_LO, 8'h00);
        wr(ADDR_TICK_CLEAR, 8'hFF);
        // Read lands mid-gap between ticks, 56 cycles after the clear
        repeat (54) @(posedge clk);
        rd_chk(ADDR_TICK_LO, 8'((56 - TCY - 1) / TCY + 1));
        rd_chk(ADDR_TICK_HI, 8'h00);
        $display("tick test done");
    endtask : t_tick

    task automatic t_soft_reset;
        @(posedge clk);
        chip_lock_flag <= 1'h1;
        wr(ADDR_SOFT_RESET, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        check(soft_reset_out, 1'h0);
        @(posedge clk);
        chip_lock_flag <= 1'h0;
        wr(ADDR_IRQ_CLOCK, 8'h01);
        wr(ADDR_SOFT_RESET, 8'h80);
        rd_chk(ADDR_IRQ_CLOCK, 8'h01);
        wr(ADDR_SOFT_RESET, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            if (i > 0)
                @(posedge clk);
            #1;
            check(soft_reset_out, i < SRST_H);
        end
        rd_chk(ADDR_IRQ_CLOCK, IRQ_CLOCK_RST);
        check(sys_clock_select, 1'h0);
        wr(ADDR_IRQ_CLOCK, 8'h01);
        do_reset;
        t_reset;
        $display("soft reset test done");
    endtask : t_soft_reset

    // ----------------------------------------
    // Sequence and watchdog
    // ----------------------------------------
    initial
    begin
        do_reset;
        t_reset;
        t_status;
        t_gates;
        t_irq_clk;
        t_tick;
        t_soft_reset;
        finish_test;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        finish_test;
    end
endmodule : scs_regs_tb
